// ===== src/pst_params.svh
// Constants for the pipe status and transmit drive control block.
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define PST_OFS_MARGIN 4'h0
`define PST_OFS_STATUS 4'h4
`define PST_OFS_PRESET 4'h8
`define PST_MARGIN_RST 32'h0000_0000
// ----------------------------------------
// Status fields
// ----------------------------------------
`define PST_STS_RSTDONE 0
`define PST_STS_RATE_LO 1
`define PST_STS_EQON 3
// ----------------------------------------
// Receive status codes
// ----------------------------------------
`define PST_RX_OK 3'h0
`define PST_RX_SKPADD 3'h1
`define PST_RX_SKPREM 3'h2
`define PST_RX_DETECT 3'h3
`define PST_RX_DECERR 3'h4
`define PST_RX_OVFL 3'h5
`define PST_RX_UNFL 3'h6
`define PST_RX_DISP 3'h7
// ----------------------------------------
// Transmit defaults and AXI response codes
// ----------------------------------------
`define PST_MARGIN_DEF 3'h0
`define PST_SWING_FULL 1'h0
`define PST_DEEMPH_6DB 1'h0
`define PST_PRESET_DEF 4'h4
`define PST_RESP_OKAY 2'h0
`define PST_RESP_SLVERR 2'h2
`endif

// ===== src/pst_pkg.sv
// Types for the pipe status and transmit drive control block.
package pst_pkg;
   typedef enum logic [1:0] {
      RATE_G1 = 2'h0,
      RATE_G2 = 2'h1,
      RATE_G3 = 2'h2,
      RATE_G4 = 2'h3
   } pst_rate_t;
   typedef enum logic [1:0] {
      EQ_IDLE = 2'h0,
      EQ_PRESET = 2'h1,
      EQ_COEFF = 2'h2,
      EQ_QUERY = 2'h3
   } pst_eqcmd_t;
   typedef enum logic [1:0] {
      LS_IDLE = 2'h0,
      LS_RUN = 2'h1,
      LS_DONE = 2'h3
   } pst_eqstate_t;
endpackage : pst_pkg

// ===== src/pst_status_ctrl.sv
// Pipe status reporting and transmit drive control with an AXI4-Lite register port.
//
// What this block and the MAC must do
// RULE1: rxValid only with lock, data, low rate.
// RULE2: MAC ignores rxValid in reset, rate change.
// RULE3: Completion pulses phyStatus exactly one cycle.
// RULE4: phyStatus held high asynchronously during reset.
// RULE5: MAC recovers itself when completion never comes.
// RULE6: Reset-done flag high until all resets finish.
// RULE7: rxElecIdle follows detector asynchronously, low rates.
// RULE8: Status codes good, skip add/remove, detected.
// RULE9: Decode error reports code 100b.
// RULE10: Elastic overflow 101b, underflow 110b.
// RULE11: Disparity error 111b at low rates.
// RULE12: Margin selector picks programmable level, default zero.
// RULE13: Swing select full or low, low rates.
// RULE14: De-emphasis select -6.0 or -3.5 dB.
// RULE15: Decode equalization command idle/preset/coeff/query.
// RULE16: MAC returns command to idle after done.
// RULE17: Vendor equalization handshake at higher rates.
// RULE18: Preset command loads preset, default 0100b.
// RULE19: MAC holds command until done, then idle.
`include "pst_params.svh"
module pst_status_ctrl #(
   parameter int LANES = 2,
   parameter bit GEN4_EQ = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Reset progress from the PHY core and transceivers
   input wire logic phyResetDone,
   input wire logic xcvrResetDone,
   // MAC rate and drive controls
   input wire logic [1:0] macRate,
   input wire logic [2:0] txMargin,
   input wire logic txSwing,
   input wire logic txDeemph,
   // Per-lane receive events from the transceiver
   input wire logic [LANES-1:0] symLock,
   input wire logic [LANES-1:0] rxDataOk,
   input wire logic [LANES-1:0] rxIdleDetect,
   input wire logic [LANES-1:0] opDone,
   input wire logic [LANES-1:0] rxPresent,
   input wire logic [LANES-1:0] skpAdded,
   input wire logic [LANES-1:0] skpRemoved,
   input wire logic [LANES-1:0] decodeErr,
   input wire logic [LANES-1:0] bufOverflow,
   input wire logic [LANES-1:0] bufUnderflow,
   input wire logic [LANES-1:0] dispErr,
   // Per-lane equalization from the MAC and transceiver
   input wire logic [2*LANES-1:0] txEqCtrl,
   input wire logic [4*LANES-1:0] txEqPreset,
   input wire logic [LANES-1:0] eqAck,
   // Status to the MAC
   output logic [LANES-1:0] rxValid,
   output logic [LANES-1:0] phyStatus,
   output logic phyStatusRst,
   output logic [LANES-1:0] rxElecIdle,
   output logic [3*LANES-1:0] rxStatus,
   output logic [LANES-1:0] txEqDone,
   // Drive settings to the transceiver
   output logic [3:0] txLevel,
   output logic txLowSwing,
   output logic txDeemph35,
   output logic [4*LANES-1:0] txPresetOut,
   output logic [LANES-1:0] txCoeffApply,
   output logic [LANES-1:0] txQuery,
   // AXI4-Lite register port
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------
   // Rate and reset tracking
   // ----------------------------------------
   pst_pkg::pst_rate_t rate;
   logic lowRate;
   logic eqOn;
   logic resetDone;
   logic [31:0] marginLevels;
   localparam logic [31:0] MARGIN_RST = `PST_MARGIN_RST;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rate <= pst_pkg::RATE_G1;
      end else begin
         rate <= pst_pkg::pst_rate_t'(macRate);
      end
   end

   assign lowRate = (rate == pst_pkg::RATE_G1) || (rate == pst_pkg::RATE_G2);
   // RULE17: vendor equalization rates
   assign eqOn = (rate == pst_pkg::RATE_G3) || (GEN4_EQ && rate == pst_pkg::RATE_G4);

   // RULE6: reset completion tracking
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         resetDone <= 1'b0;
      end else if (phyResetDone && xcvrResetDone) begin
         resetDone <= 1'b1;
      end
   end

   // RULE6: flag high from reset
   assign phyStatusRst = ~resetDone;

   // ----------------------------------------
   // Transmit drive
   // ----------------------------------------
   logic [3:0] levelSel;

   // RULE12: margin to programmable level
   always_comb begin
      levelSel = marginLevels[4*txMargin +: 4];
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         txLevel <= MARGIN_RST[3:0];
         txLowSwing <= `PST_SWING_FULL;
         txDeemph35 <= 1'b1;
      end else begin
         txLevel <= levelSel;
         // RULE13: swing at low rates
         txLowSwing <= lowRate ? txSwing : `PST_SWING_FULL;
         // RULE14: de-emphasis at low rates
         txDeemph35 <= lowRate ? (txDeemph != `PST_DEEMPH_6DB) : 1'b1;
      end
   end

   // ----------------------------------------
   // Per-lane status and equalization
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gLane
         logic doneSeen;
         logic donePulse;
         logic [2:0] next_code;
         pst_pkg::pst_eqstate_t eqState;
         pst_pkg::pst_eqcmd_t cmd;

         assign cmd = pst_pkg::pst_eqcmd_t'(txEqCtrl[2*g +: 2]);

         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               doneSeen <= 1'b0;
               donePulse <= 1'b0;
            end else begin
               doneSeen <= opDone[g];
               // RULE3: one cycle per completion
               donePulse <= opDone[g] && !doneSeen && resetDone;
            end
         end

         // RULE4: asynchronous high in reset
         assign phyStatus[g] = ~resetDone | donePulse;

         // RULE7: asynchronous idle report
         assign rxElecIdle[g] = rxIdleDetect[g] & lowRate;

         // RULE8: status code priority
         always_comb begin
            if (decodeErr[g]) begin
               // RULE9: decode error code
               next_code = `PST_RX_DECERR;
            end else if (dispErr[g] && lowRate) begin
               // RULE11: disparity at low rates
               next_code = `PST_RX_DISP;
            end else if (bufOverflow[g]) begin
               // RULE10: elastic buffer overflow
               next_code = `PST_RX_OVFL;
            end else if (bufUnderflow[g]) begin
               // RULE10: elastic buffer underflow
               next_code = `PST_RX_UNFL;
            end else if (skpAdded[g]) begin
               next_code = `PST_RX_SKPADD;
            end else if (skpRemoved[g]) begin
               next_code = `PST_RX_SKPREM;
            end else if (opDone[g] && !doneSeen && rxPresent[g]) begin
               next_code = `PST_RX_DETECT;
            end else begin
               next_code = `PST_RX_OK;
            end
         end

         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               rxStatus[3*g +: 3] <= `PST_RX_OK;
               rxValid[g] <= 1'b0;
            end else begin
               rxStatus[3*g +: 3] <= next_code;
               // RULE1: valid needs lock and data
               rxValid[g] <= symLock[g] && rxDataOk[g] && lowRate;
            end
         end

         // RULE15: command decode and sequence
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               eqState <= pst_pkg::LS_IDLE;
               txEqDone[g] <= 1'b0;
               txCoeffApply[g] <= 1'b0;
               txQuery[g] <= 1'b0;
               txPresetOut[4*g +: 4] <= `PST_PRESET_DEF;
            end else begin
               txCoeffApply[g] <= 1'b0;
               txQuery[g] <= 1'b0;
               unique case (eqState)
                  pst_pkg::LS_IDLE: begin
                     txEqDone[g] <= 1'b0;
                     if (eqOn && cmd != pst_pkg::EQ_IDLE) begin
                        eqState <= pst_pkg::LS_RUN;
                        // RULE18: preset load
                        if (cmd == pst_pkg::EQ_PRESET) begin
                           txPresetOut[4*g +: 4] <= txEqPreset[4*g +: 4];
                        end
                        txCoeffApply[g] <= (cmd == pst_pkg::EQ_COEFF);
                        txQuery[g] <= (cmd == pst_pkg::EQ_QUERY);
                     end
                  end
                  pst_pkg::LS_RUN: begin
                     if (eqAck[g]) begin
                        eqState <= pst_pkg::LS_DONE;
                        txEqDone[g] <= 1'b1;
                     end
                  end
                  pst_pkg::LS_DONE: begin
                     // RULE16: wait for idle command
                     if (cmd == pst_pkg::EQ_IDLE) begin
                        eqState <= pst_pkg::LS_IDLE;
                        txEqDone[g] <= 1'b0;
                     end
                  end
                  default: begin
                     eqState <= pst_pkg::LS_IDLE;
                  end
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   logic awHeld;
   logic wHeld;
   logic [3:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;

   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 4'h0;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PST_RESP_OKAY;
      end else if (s_axi_bvalid) begin
         if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end else if (awHeld && wHeld) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awAddr == `PST_OFS_MARGIN) ? `PST_RESP_OKAY : `PST_RESP_SLVERR;
      end else begin
         if (s_axi_awvalid && !awHeld) begin
            awHeld <= 1'b1;
            awAddr <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && !wHeld) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
      end
   end

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : gByte
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               marginLevels[8*b +: 8] <= MARGIN_RST[8*b +: 8];
            end else if (awHeld && wHeld && !s_axi_bvalid && awAddr == `PST_OFS_MARGIN && wStrb[b]) begin
               marginLevels[8*b +: 8] <= wData[8*b +: 8];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   logic [31:0] next_rdata;
   logic [31:0] presetWord;

   always_comb begin
      presetWord = 32'h0000_0000;
      for (int i = 0; i < LANES && i < 8; i++) begin
         presetWord[4*i +: 4] = txPresetOut[4*i +: 4];
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[3:2], 2'h0})
         `PST_OFS_MARGIN: next_rdata = marginLevels;
         `PST_OFS_STATUS: begin
            next_rdata[`PST_STS_RSTDONE] = resetDone;
            next_rdata[`PST_STS_RATE_LO +: 2] = rate;
            next_rdata[`PST_STS_EQON] = eqOn;
         end
         `PST_OFS_PRESET: next_rdata = presetWord;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PST_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= (s_axi_araddr[3:2] == 2'h3) ? `PST_RESP_SLVERR : `PST_RESP_OKAY;
      end
   end

endmodule : pst_status_ctrl

// ===== tb/pst_assertions.sv
// Concurrent checks on the ports of the pipe status block.
module pst_assertions #(
   parameter int LANES = 2
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Inputs watched
   input wire logic phyResetDone,
   input wire logic xcvrResetDone,
   input wire logic [1:0] macRate,
   input wire logic [LANES-1:0] symLock,
   input wire logic [LANES-1:0] rxDataOk,
   input wire logic [LANES-1:0] rxIdleDetect,
   input wire logic [LANES-1:0] opDone,
   input wire logic [LANES-1:0] decodeErr,
   input wire logic [LANES-1:0] bufOverflow,
   input wire logic [LANES-1:0] dispErr,
   input wire logic [2*LANES-1:0] txEqCtrl,
   input wire logic [4*LANES-1:0] txEqPreset,
   // Outputs watched
   input wire logic [LANES-1:0] rxValid,
   input wire logic [LANES-1:0] phyStatus,
   input wire logic phyStatusRst,
   input wire logic [LANES-1:0] rxElecIdle,
   input wire logic [3*LANES-1:0] rxStatus,
   input wire logic [LANES-1:0] txEqDone,
   input wire logic [4*LANES-1:0] txPresetOut
);
   timeunit 1ns / 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_idle_then_preset;
      txEqCtrl[1:0] == 2'h0 ##1 txEqCtrl[1:0] == 2'h1 && macRate == 2'h2 && $past(macRate) == 2'h2;
   endsequence
   a_rst_hold: assert property (!(phyResetDone && xcvrResetDone) |=> phyStatusRst)
      else $error("reset flag fell early");
   a_status_rst: assert property (phyStatusRst |-> &phyStatus)
      else $error("completion low in reset");
   a_pulse_single: assert property (
      !phyStatusRst && phyStatus[0] |-> $past(opDone[0]) && !$past(opDone[0], 2) ##1 !phyStatus[0])
      else $error("completion pulse wrong");
   a_valid_lock: assert property (rxValid[0] |-> $past(symLock[0] && rxDataOk[0]))
      else $error("valid without lock");
   a_idle_follow: assert property (rxElecIdle[0] |-> rxIdleDetect[0])
      else $error("idle without detect");
   a_decode_code: assert property ($past(decodeErr[0]) |-> rxStatus[2:0] == 3'h4)
      else $error("decode code wrong");
   a_ovfl_code: assert property (
      $past(bufOverflow[0] && !decodeErr[0] && !dispErr[0]) |-> rxStatus[2:0] == 3'h5)
      else $error("overflow code wrong");
   a_done_clear: assert property (txEqDone[0] && txEqCtrl[1:0] == 2'h0 |=> !txEqDone[0])
      else $error("done stuck after idle");
   a_preset_load: assert property (
      s_idle_then_preset |=> txPresetOut[3:0] == $past(txEqPreset[3:0]))
      else $error("preset not loaded");
endmodule : pst_assertions

bind pst_status_ctrl pst_assertions #(.LANES(LANES)) u_chk (.*);

// ===== tb/pst_mac_model.sv
// Model of the MAC side of the equalization command handshake.
module pst_mac_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Request from the bench
   input wire logic go,
   input wire logic [1:0] cmd,
   input wire logic [3:0] lag,
   // Handshake with the block
   input wire logic eqDone,
   output logic [1:0] eqCtrl,
   output logic busy
);
   timeunit 1ns / 1ns;
   logic [3:0] holdCnt;
   logic [3:0] giveUp;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {eqCtrl, busy, holdCnt, giveUp} <= '0;
      end else if (go && !busy) begin
         {eqCtrl, busy, holdCnt, giveUp} <= {cmd, 1'b1, lag, 4'hf};
      end else if (busy && (eqDone ? holdCnt == 4'h0 : giveUp == 4'h0)) begin
         {eqCtrl, busy} <= '0;
      end else if (busy && eqDone) begin
         holdCnt <= holdCnt - 4'h1;
      end else if (busy) begin
         giveUp <= giveUp - 4'h1;
      end
   end
endmodule : pst_mac_model

// ===== tb/testbench.sv
// Self-checking testbench for the pipe status block.
module testbench;
   timeunit 1ns / 1ns;
   logic mclk, rst_b, phyResetDone, xcvrResetDone, txSwing, txDeemph, phyStatusRst, txLowSwing;
   logic txDeemph35, eqGo, macBusy, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] macRate, eqCmd, macEq, symLock, rxDataOk, rxIdleDetect, opDone, rxPresent;
   logic [1:0] skpAdded, skpRemoved, decodeErr, bufOverflow, bufUnderflow, dispErr, eqAck;
   logic [1:0] rxValid, phyStatus, rxElecIdle, txEqDone, txCoeffApply, txQuery;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0] txMargin;
   logic [3:0] txEqCtrl, txLevel, eqLag, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [5:0] rxStatus;
   logic [7:0] txEqPreset, txPresetOut;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   assign txEqCtrl = {2'h0, macEq};
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   pst_status_ctrl u_dut (.*);
   pst_mac_model u_mac (.mclk(mclk), .rst_b(rst_b), .go(eqGo), .cmd(eqCmd), .lag(eqLag),
      .eqDone(txEqDone[0]), .eqCtrl(macEq), .busy(macBusy));
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         print_verdict;
      end
   end
   task automatic print_verdict;
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      {aw, w} = 2'h3;
      @(posedge mclk) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      while (aw || w) begin
         @(posedge mclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge mclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk) {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge mclk);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic t_reset;
      tick(12);
      chk(phyStatusRst === 1'b1 && phyStatus === 2'h3, "status in reset");
      chk(txPresetOut === 8'h44 && txLevel === 4'h0, "preset reset");
      chk(txLowSwing === 1'b0 && txDeemph35 === 1'b1, "drive reset");
      rst_b <= 1'b1;
      tick(3);
      phyResetDone <= 1'b1;
      tick(3);
      @(negedge mclk);
      chk(phyStatusRst === 1'b1, "flag fell early");
      @(posedge mclk) xcvrResetDone <= 1'b1;
      tick(1);
      @(negedge mclk);
      chk(phyStatusRst === 1'b0 && phyStatus === 2'h0, "flag stuck");
   endtask : t_reset
   task automatic t_complete;
      int hi = 0;
      @(posedge mclk) {opDone, rxPresent} <= 4'h5;
      repeat (5) begin
         @(negedge mclk);
         if (phyStatus[0] === 1'b1) hi++;
         if (phyStatus[0] === 1'b1) chk(rxStatus[2:0] === 3'h3, "detect code");
      end
      chk(hi == 1 && phyStatus[1] === 1'b0, "pulse count");
      @(posedge mclk) {opDone, rxPresent} <= 4'h0;
   endtask : t_complete
   task automatic t_codes;
      logic [5:0] ev [9] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h24, 6'h18, 6'h00};
      logic [2:0] code [9] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h4, 3'h5, 3'h0};
      for (int i = 0; i < 9; i++) begin
         @(posedge mclk);
         {dispErr[0], bufUnderflow[0], bufOverflow[0], decodeErr[0], skpRemoved[0], skpAdded[0]} <= ev[i];
         tick(1);
         @(negedge mclk);
         chk(rxStatus[2:0] === code[i] && rxStatus[5:3] === 3'h0, "status code");
      end
      @(posedge mclk) {macRate, dispErr} <= 4'h9;
      tick(2);
      @(negedge mclk);
      chk(rxStatus[2:0] === 3'h0, "disparity at high rate");
      @(posedge mclk) {macRate, dispErr} <= 4'h0;
   endtask : t_codes
   task automatic t_valid;
      @(posedge mclk) {symLock, rxDataOk, rxIdleDetect} <= 6'h1d;
      tick(2);
      @(negedge mclk);
      chk(rxValid === 2'h1 && rxElecIdle === 2'h1, "low rate status");
      @(posedge mclk) macRate <= 2'h3;
      tick(3);
      @(negedge mclk);
      chk(rxValid === 2'h0 && rxElecIdle === 2'h0, "high rate gating");
      @(posedge mclk) {macRate, symLock, rxIdleDetect} <= 6'h10;
   endtask : t_valid
   task automatic t_drive;
      axi_wr(4'h0, 32'h8765_4321, rsp);
      axi_rd(4'h0, rdat, rsp);
      chk(rdat === 32'h8765_4321 && rsp === 2'h0, "margin readback");
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk) {txMargin, txSwing, txDeemph} <= {k[2:0], k[0], k[1]};
         tick(2);
         @(negedge mclk);
         chk(txLevel === 4'(k + 1) && txLowSwing === k[0] && txDeemph35 === k[1], "drive");
      end
      @(posedge mclk) txMargin <= 3'h0;
      axi_wr(4'h4, 32'h0, rsp);
      chk(rsp === 2'h2, "read-only write");
      axi_rd(4'hc, rdat, rsp);
      chk(rsp === 2'h2 && rdat === 32'h0, "unmapped read");
      axi_rd(4'h8, rdat, rsp);
      chk(rdat[7:0] === 8'h44, "default preset");
   endtask : t_drive
   task automatic eq_go(input logic [1:0] c, output logic s);
      @(posedge mclk) {eqCmd, eqGo} <= {c, 1'b1};
      @(posedge mclk) eqGo <= 1'b0;
      s = 1'b0;
      repeat (4) begin
         @(negedge mclk);
         s = s | (c == 2'h3 ? txQuery[0] : txCoeffApply[0]);
      end
   endtask : eq_go
   task automatic t_eq;
      logic s;
      for (int c = 1; c < 4; c++) begin
         @(posedge mclk) {macRate, txEqPreset, eqLag} <= {(c == 2) ? 2'h3 : 2'h2, 8'h39, 4'h2};
         tick(1);
         eq_go(c[1:0], s);
         chk(s === (c != 1) && txPresetOut === 8'h49, "eq decode");
         @(posedge mclk) eqAck <= 2'h1;
         tick(2);
         @(negedge mclk);
         chk(txEqDone[0] === 1'b1 && txEqCtrl[1:0] === c[1:0], "done while held");
         @(posedge mclk) eqAck <= 2'h0;
         while (macBusy) @(posedge mclk);
         tick(1);
         @(negedge mclk);
         chk(txEqDone[0] === 1'b0, "done after idle");
      end
      @(posedge mclk) macRate <= 2'h0;
      tick(1);
      eq_go(2'h2, s);
      chk(s === 1'b0 && txEqDone === 2'h0, "refused at low rate");
      while (macBusy) @(posedge mclk);
   endtask : t_eq
   initial begin
      {rst_b, phyResetDone, xcvrResetDone, macRate, txMargin, txSwing, symLock, rxDataOk} = '0;
      {rxIdleDetect, opDone, rxPresent, skpAdded, skpRemoved, decodeErr, bufOverflow} = '0;
      {bufUnderflow, dispErr, eqAck, txEqPreset, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, eqCmd, eqGo, eqLag} = '0;
      {txDeemph, s_axi_wstrb} = 5'h1f;
      t_reset;
      t_complete;
      t_codes;
      t_valid;
      t_drive;
      t_eq;
      print_verdict;
   end
endmodule : testbench
